/* File: shared/aac_map.svh */
// register offsets, field positions, reset values and timing counts
`ifndef AAC_MAP_SVH
`define AAC_MAP_SVH
`define AAC_OFF_REMOTE_ALARM   8'h00
`define AAC_OFF_EBIT_ACTION    8'h04
`define AAC_OFF_SYS_AIS_LB     8'h08
`define AAC_OFF_MF_TIMER       8'h0c
`define AAC_OFF_TS16_LINE      8'h10
`define AAC_OFF_TS16_SYS       8'h14
`define AAC_OFF_DL_SQUELCH     8'h18
`define AAC_OFF_STATUS         8'h1c
`define AAC_NUM_CFG            7
`define AAC_CFG_RESET          8'h00
`define AAC_RA_FAL             0
`define AAC_RA_TS16            1
`define AAC_RA_TS0             2
`define AAC_RA_TMR             3
`define AAC_RA_SA6_8           4
`define AAC_RA_SA6_C           5
`define AAC_RA_FS12            6
`define AAC_RA_DEMAND          7
`define AAC_EB_CRC             3
`define AAC_EB_TS0             4
`define AAC_EB_TMR             5
`define AAC_SA_FAL             0
`define AAC_SA_TMR             1
`define AAC_SA_INBAND_LB       4
`define AAC_SA_FDL_LINE_LB     6
`define AAC_SA_FDL_PAY_LB      7
`define AAC_T16_AUTO           4
`define AAC_T16_DEMAND         5
`define AAC_T16_SYS_AIS        6
`define AAC_DL_SQUELCH         4
`define AAC_SA6_CODE_8         4'h8
`define AAC_SA6_CODE_C         4'hc
`define AAC_TMR_SHORT_MS       100
`define AAC_TMR_LONG_MS        400
`define AAC_CLK_KHZ            50000
`define AAC_RESP_OKAY          2'h0
`define AAC_RESP_SLVERR        2'h2
`endif

/* File: shared/aac_pkg.sv */
// types of the alarm action controller
package aac_pkg;
  typedef enum logic [2:0] {
    AAC_FMT_ESF   = 3'b000,
    AAC_FMT_D4_US = 3'b001,
    AAC_FMT_D4_JP = 3'b010,
    AAC_FMT_DDS   = 3'b011,
    AAC_FMT_SLC96 = 3'b100,
    AAC_FMT_E1    = 3'b101
  } aac_fmt_e;
  typedef struct packed {
    logic       frame_align_loss;
    logic       ts16_mf_align_loss;
    logic       ts0_mf_align_loss;
    logic       crc4_err;
    logic [3:0] rx_spare6_code;
    logic       inband_lb_on;
    logic       inband_lb_off;
    logic       fdl_line_lb_on;
    logic       fdl_line_lb_off;
    logic       fdl_pay_lb_on;
    logic       fdl_pay_lb_off;
    logic       fdl_slot;
  } aac_rx_s;
  typedef struct packed {
    logic remote_frame_alarm;
    logic ebit_zero;
    logic sys_ais;
    logic ts16_rma;
    logic sys_ts16_ais;
    logic line_loopback;
    logic payload_loopback;
    logic fs12_one;
    logic ts_bit2_zero;
    logic e1_abit_one;
    logic dds_ts24_bit6_zero;
    logic dl_force;
    logic dl_bit;
  } aac_tx_s;
endpackage

/* File: hw/aac_alarm_ctrl.sv */
// alarm action controller with axi4-lite register slave
//
// The implementer's own choices: register access over AXI4-Lite and the address map.
`include "aac_map.svh"
`timescale 1ns/10ps
`default_nettype none

module aac_alarm_ctrl #(
  parameter int unsigned P_MS_CYC = `AAC_CLK_KHZ
) (
  // clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_rst_n,
  // framer side
  input  wire aac_pkg::aac_fmt_e i_fmt,
  input  wire aac_pkg::aac_rx_s  i_rx,
  output var  aac_pkg::aac_tx_s  o_tx,
  // axi4-lite write
  input  wire logic [7:0]        i_awaddr,
  input  wire logic              i_awvalid,
  output logic                   o_awready,
  input  wire logic [31:0]       i_wdata,
  input  wire logic [3:0]        i_wstrb,
  input  wire logic              i_wvalid,
  output logic                   o_wready,
  output logic [1:0]             o_bresp,
  output logic                   o_bvalid,
  input  wire logic              i_bready,
  // axi4-lite read
  input  wire logic [7:0]        i_araddr,
  input  wire logic              i_arvalid,
  output logic                   o_arready,
  output logic [31:0]            o_rdata,
  output logic [1:0]             o_rresp,
  output logic                   o_rvalid,
  input  wire logic              i_rready
);
  import aac_pkg::*;

  localparam int unsigned MS_W = $clog2(P_MS_CYC);
  localparam logic [8:0] TMR_SHORT = 9'(`AAC_TMR_SHORT_MS);
  localparam logic [8:0] TMR_LONG  = 9'(`AAC_TMR_LONG_MS);

  // register index decode; bit 3 flags a mapped word
  function automatic logic [3:0] aac_idx(input logic [7:0] a);
    aac_idx = (a[7:5] == 3'h0) ? {1'b1, a[4:2]} : 4'h0;
  endfunction

  logic [7:0]  cfg_q [`AAC_NUM_CFG];
  logic        aw_hold_q, w_hold_q, bvalid_q, rvalid_q, awready_q, wready_q, arready_q;
  logic [7:0]  awaddr_q;
  logic [7:0]  wdata_q;
  logic        wstrb0_q;
  logic [1:0]  bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic [MS_W-1:0] ms_cnt_q;
  logic [8:0]  mf_cnt_q;
  logic [3:0]  esf_pos_q;
  logic        line_lb_q, pay_lb_q;
  aac_tx_s     tx_q, tx_d;
  logic        mf_exp;

  // axi write channel
  wire       aw_take = i_awvalid & awready_q;
  wire       w_take  = i_wvalid & wready_q;
  wire       wr_do   = aw_hold_q & w_hold_q & ~bvalid_q;
  wire [3:0] wr_idx  = aac_idx(awaddr_q);
  wire       wr_ok   = wr_idx[3] & (wr_idx[2:0] != 3'h7);
  wire       aw_hold_d = (aw_hold_q | aw_take) & ~wr_do;
  wire       w_hold_d  = (w_hold_q | w_take) & ~wr_do;
  wire       bvalid_d  = wr_do | (bvalid_q & ~i_bready);

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      awaddr_q  <= 8'h00;
      wdata_q   <= 8'h00;
      wstrb0_q  <= 1'b0;
      bresp_q   <= `AAC_RESP_OKAY;
    end else begin
      aw_hold_q <= aw_hold_d;
      w_hold_q  <= w_hold_d;
      bvalid_q  <= bvalid_d;
      // each channel ready while its own slot is free and no response is pending, so either may come first
      awready_q <= ~aw_hold_d & ~bvalid_d;
      wready_q  <= ~w_hold_d & ~bvalid_d;
      if (aw_take) begin
        awaddr_q <= i_awaddr;
      end
      if (w_take) begin
        wdata_q  <= i_wdata[7:0];
        wstrb0_q <= i_wstrb[0];
      end
      if (wr_do) begin
        bresp_q <= wr_ok ? `AAC_RESP_OKAY : `AAC_RESP_SLVERR;
      end
    end
  end

  // configuration bytes, all clear at reset
  for (genvar g = 0; g < `AAC_NUM_CFG; g++) begin : g_cfg
    always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
        cfg_q[g] <= `AAC_CFG_RESET;
      end else if (wr_do && wr_ok && wstrb0_q && wr_idx[2:0] == 3'(g)) begin
        cfg_q[g] <= wdata_q;
      end
    end
  end

  wire [7:0] ra  = cfg_q[0];
  wire [7:0] eb  = cfg_q[1];
  wire [7:0] sa  = cfg_q[2];
  wire [7:0] mt  = cfg_q[3];
  wire [7:0] t16 = cfg_q[4];
  wire [7:0] t16s = cfg_q[5];
  wire [7:0] dl  = cfg_q[6];

  // axi read channel
  wire       ar_take  = i_arvalid & arready_q;
  wire       rvalid_d = ar_take | (rvalid_q & ~i_rready);
  wire [3:0] rd_idx   = aac_idx(i_araddr);
  wire [7:0] status   = {mf_exp, tx_q.payload_loopback, tx_q.line_loopback,
                         tx_q.sys_ts16_ais, tx_q.ts16_rma, tx_q.sys_ais,
                         tx_q.ebit_zero, tx_q.remote_frame_alarm};
  wire [7:0] rd_byte  = (rd_idx[2:0] == 3'h7) ? status : cfg_q[rd_idx[2:0]];

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      rvalid_q  <= 1'b0;
      arready_q <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= `AAC_RESP_OKAY;
    end else begin
      rvalid_q  <= rvalid_d;
      arready_q <= ~rvalid_d;
      if (ar_take) begin
        rdata_q <= rd_idx[3] ? {24'h00_0000, rd_byte} : 32'h0000_0000;
        rresp_q <= rd_idx[3] ? `AAC_RESP_OKAY : `AAC_RESP_SLVERR;
      end
    end
  end

  // multiframe loss timer on millisecond ticks
  wire ms_tick  = (ms_cnt_q == MS_W'(P_MS_CYC - 1));
  wire sel_short = ~mt[7] & mt[2] & mt[0];
  wire sel_long  = ~mt[7] & mt[3] & mt[0];
  assign mf_exp = (sel_short & (mf_cnt_q >= TMR_SHORT))
              | (sel_long & (mf_cnt_q >= TMR_LONG));

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ms_cnt_q <= '0;
      mf_cnt_q <= 9'h000;
    end else begin
      ms_cnt_q <= ms_tick ? '0 : ms_cnt_q + 1'b1;
      if (!i_rx.ts0_mf_align_loss) begin
        mf_cnt_q <= 9'h000;
      end else if (ms_tick && mf_cnt_q < TMR_LONG) begin
        mf_cnt_q <= mf_cnt_q + 9'h001;
      end
    end
  end

  // automatic loopbacks from received codes
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      line_lb_q <= 1'b0;
      pay_lb_q  <= 1'b0;
    end else begin
      if (sa[`AAC_SA_INBAND_LB] && i_rx.inband_lb_on) begin
        line_lb_q <= 1'b1;
      end else if (sa[`AAC_SA_INBAND_LB] && i_rx.inband_lb_off) begin
        line_lb_q <= 1'b0;
      end else if (sa[`AAC_SA_FDL_LINE_LB] && i_rx.fdl_line_lb_on) begin
        line_lb_q <= 1'b1;
      end else if (sa[`AAC_SA_FDL_LINE_LB] && i_rx.fdl_line_lb_off) begin
        line_lb_q <= 1'b0;
      end
      if (sa[`AAC_SA_FDL_PAY_LB] && i_rx.fdl_pay_lb_on) begin
        pay_lb_q <= 1'b1;
      end else if (sa[`AAC_SA_FDL_PAY_LB] && i_rx.fdl_pay_lb_off) begin
        pay_lb_q <= 1'b0;
      end
    end
  end

  // esf alarm pattern position, steps once per data-link slot
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      esf_pos_q <= 4'h0;
    end else if (i_rx.fdl_slot) begin
      esf_pos_q <= esf_pos_q + 4'h1;
    end
  end

  wire fmt_e1  = (i_fmt == AAC_FMT_E1);
  wire fmt_esf = (i_fmt == AAC_FMT_ESF);
  wire demand  = ra[`AAC_RA_DEMAND];
  wire rfa_auto =
      (ra[`AAC_RA_FAL] & i_rx.frame_align_loss)
    | (ra[`AAC_RA_TS16] & i_rx.ts16_mf_align_loss)
    | (ra[`AAC_RA_TS0] & i_rx.ts0_mf_align_loss)
    | (ra[`AAC_RA_TMR] & mf_exp)
    | (ra[`AAC_RA_SA6_8] & (i_rx.rx_spare6_code == `AAC_SA6_CODE_8))
    | (ra[`AAC_RA_SA6_C] & (i_rx.rx_spare6_code == `AAC_SA6_CODE_C));
  wire dl_squelch = dl[`AAC_DL_SQUELCH] & (fmt_esf | (i_fmt == AAC_FMT_SLC96));

  always_comb begin
    tx_d = '0;
    tx_d.remote_frame_alarm = rfa_auto | demand;
    tx_d.ebit_zero = (eb[`AAC_EB_CRC] & i_rx.crc4_err)
                   | (eb[`AAC_EB_TS0] & i_rx.ts0_mf_align_loss)
                   | (eb[`AAC_EB_TMR] & mf_exp);
    tx_d.sys_ais = (sa[`AAC_SA_FAL] & i_rx.frame_align_loss)
                 | (sa[`AAC_SA_TMR] & mf_exp);
    tx_d.ts16_rma = (t16[`AAC_T16_AUTO] & i_rx.ts16_mf_align_loss)
                  | (t16[`AAC_T16_DEMAND] & fmt_e1);
    tx_d.sys_ts16_ais = t16s[`AAC_T16_SYS_AIS] & i_rx.ts16_mf_align_loss;
    tx_d.line_loopback = line_lb_q;
    tx_d.payload_loopback = pay_lb_q;
    tx_d.fs12_one = ra[`AAC_RA_FS12] & (i_fmt == AAC_FMT_D4_JP);
    tx_d.ts_bit2_zero = demand & (i_fmt == AAC_FMT_D4_US);
    tx_d.e1_abit_one = fmt_e1 & (demand | rfa_auto);
    tx_d.dds_ts24_bit6_zero = demand & (i_fmt == AAC_FMT_DDS);
    tx_d.dl_force = dl_squelch | (demand & fmt_esf);
    tx_d.dl_bit = dl_squelch | ~esf_pos_q[3];
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      tx_q <= '0;
    end else begin
      tx_q <= tx_d;
    end
  end

  assign o_tx      = tx_q;
  assign o_awready = awready_q;
  assign o_wready  = wready_q;
  assign o_bvalid  = bvalid_q;
  assign o_bresp   = bresp_q;
  assign o_arready = arready_q;
  assign o_rvalid  = rvalid_q;
  assign o_rdata   = rdata_q;
  assign o_rresp   = rresp_q;

  property p_rfa_fal;
    @(posedge i_clk) disable iff (!i_rst_n)
      (ra[0] && i_rx.frame_align_loss) |=> tx_q.remote_frame_alarm;
  endproperty
  a_rfa_fal: assert property (p_rfa_fal) else $error("rfa missing on fal");

  property p_rfa_off;
    @(posedge i_clk) disable iff (!i_rst_n)
      (ra == 8'h00) |=> !tx_q.remote_frame_alarm;
  endproperty
  a_rfa_off: assert property (p_rfa_off) else $error("rfa without cause");

  property p_ebit_crc;
    @(posedge i_clk) disable iff (!i_rst_n)
      (eb[3] && i_rx.crc4_err) |=> tx_q.ebit_zero;
  endproperty
  a_ebit_crc: assert property (p_ebit_crc) else $error("e bit not zeroed");

  property p_sys_ais;
    @(posedge i_clk) disable iff (!i_rst_n)
      (sa[0] && i_rx.frame_align_loss) |=> tx_q.sys_ais;
  endproperty
  a_sys_ais: assert property (p_sys_ais) else $error("system ais missing");

  property p_tmr_exp;
    @(posedge i_clk) disable iff (!i_rst_n)
      mf_exp |-> (mf_cnt_q >= TMR_SHORT) && $past(i_rx.ts0_mf_align_loss);
  endproperty
  a_tmr_exp: assert property (p_tmr_exp) else $error("early timer expiry");

  property p_ts16_rma;
    @(posedge i_clk) disable iff (!i_rst_n)
      (t16[4] && i_rx.ts16_mf_align_loss) |=> tx_q.ts16_rma;
  endproperty
  a_ts16_rma: assert property (p_ts16_rma) else $error("ts16 alarm missing");

  property p_ts16_ais;
    @(posedge i_clk) disable iff (!i_rst_n)
      (t16s[6] && i_rx.ts16_mf_align_loss) |=> tx_q.sys_ts16_ais;
  endproperty
  a_ts16_ais: assert property (p_ts16_ais) else $error("ts16 ais missing");

  property p_line_lb;
    @(posedge i_clk) disable iff (!i_rst_n)
      (sa[4] && i_rx.inband_lb_on) |=> ##1 tx_q.line_loopback;
  endproperty
  a_line_lb: assert property (p_line_lb) else $error("line loopback not set");

  property p_squelch;
    @(posedge i_clk) disable iff (!i_rst_n)
      (dl[4] && (fmt_esf || i_fmt == AAC_FMT_SLC96)) |=> (tx_q.dl_force && tx_q.dl_bit);
  endproperty
  a_squelch: assert property (p_squelch) else $error("data link not squelched");

  property p_rfa_ts16;
    @(posedge i_clk) disable iff (!i_rst_n)
      (ra[1] && i_rx.ts16_mf_align_loss) |=> tx_q.remote_frame_alarm;
  endproperty
  a_rfa_ts16: assert property (p_rfa_ts16) else $error("rfa missing on ts16 loss");

  property p_rfa_ts0;
    @(posedge i_clk) disable iff (!i_rst_n)
      (ra[2] && i_rx.ts0_mf_align_loss) |=> tx_q.remote_frame_alarm;
  endproperty
  a_rfa_ts0: assert property (p_rfa_ts0) else $error("rfa missing on ts0 loss");

  property p_rfa_sa6;
    @(posedge i_clk) disable iff (!i_rst_n)
      (ra[4] && i_rx.rx_spare6_code == 4'h8) |=> tx_q.remote_frame_alarm;
  endproperty
  a_rfa_sa6: assert property (p_rfa_sa6) else $error("rfa missing on spare code");

  property p_ebit_ts0;
    @(posedge i_clk) disable iff (!i_rst_n)
      (eb[4] && i_rx.ts0_mf_align_loss) |=> tx_q.ebit_zero;
  endproperty
  a_ebit_ts0: assert property (p_ebit_ts0) else $error("e bit not zeroed on ts0 loss");

  property p_fs12;
    @(posedge i_clk) disable iff (!i_rst_n)
      (ra[6] && i_fmt == AAC_FMT_D4_JP) |=> tx_q.fs12_one;
  endproperty
  a_fs12: assert property (p_fs12) else $error("frame 12 bit not set");

  property p_pay_lb;
    @(posedge i_clk) disable iff (!i_rst_n)
      (sa[7] && i_rx.fdl_pay_lb_on) |=> ##1 tx_q.payload_loopback;
  endproperty
  a_pay_lb: assert property (p_pay_lb) else $error("payload loopback not set");

endmodule // aac_alarm_ctrl

`default_nettype wire

/* File: sim/aac_line_model.sv */
// far-end line model: data-link slot timing and bit capture
`timescale 1ns/10ps
`default_nettype none

module aac_line_model (
  // clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  // line side
  input  wire aac_pkg::aac_tx_s i_tx,
  output logic                  o_slot,
  output logic [31:0]           o_hist
);
  import aac_pkg::*;
  logic [1:0] div_q;
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      div_q  <= 2'h0;
      o_slot <= 1'b0;
      o_hist <= 32'h0;
    end else begin
      div_q  <= div_q + 2'h1;
      o_slot <= (div_q == 2'h3);
      // line sees the forced bit, else zero
      if (o_slot) o_hist <= {o_hist[30:0], i_tx.dl_force & i_tx.dl_bit};
    end
  end
endmodule // aac_line_model
`default_nettype wire

/* File: sim/aac_alarm_ctrl_tb.sv */
// self-checking bench of the alarm action controller
`include "aac_map.svh"
`timescale 1ns/10ps
`default_nettype none

module aac_alarm_ctrl_tb;
  import aac_pkg::*;
  localparam int unsigned MS = 4;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  aac_fmt_e    fmt = AAC_FMT_E1;
  aac_rx_s     rx = '0;
  aac_rx_s     rx_w;
  aac_tx_s     tx;
  logic [7:0]  awa = 8'h00;
  logic [7:0]  ara = 8'h00;
  logic [31:0] wd = 32'h0;
  logic [3:0]  ws = 4'h0;
  logic        awv = 1'b0;
  logic        wv = 1'b0;
  logic        br = 1'b0;
  logic        arv = 1'b0;
  logic        rr = 1'b0;
  logic        awr, wr_rdy, bv, arr, rv, slot;
  logic [1:0]  bresp, rresp, r;
  logic [31:0] rdata, d, hist;
  logic        ok;
  int          miscompares = 0;
  int          n_tests = 0;

  always #10 clk = ~clk;
  always_comb begin
    rx_w = rx;
    rx_w.fdl_slot = slot;
  end

  aac_alarm_ctrl #(.P_MS_CYC(MS)) i_dut (
    .i_clk(clk), .i_rst_n(rst_n), .i_fmt(fmt), .i_rx(rx_w), .o_tx(tx),
    .i_awaddr(awa), .i_awvalid(awv), .o_awready(awr), .i_wdata(wd), .i_wstrb(ws),
    .i_wvalid(wv), .o_wready(wr_rdy), .o_bresp(bresp), .o_bvalid(bv), .i_bready(br),
    .i_araddr(ara), .i_arvalid(arv), .o_arready(arr), .o_rdata(rdata),
    .o_rresp(rresp), .o_rvalid(rv), .i_rready(rr)
  );
  aac_line_model i_line (.i_clk(clk), .i_rst_n(rst_n), .i_tx(tx), .o_slot(slot),
    .o_hist(hist));

  task automatic summarize;
    if (miscompares == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v, output logic [1:0] rs);
    awa <= a;
    wd <= {24'h0, v};
    ws <= 4'hf;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    do begin
      @(posedge clk);
      if (awv && awr === 1'b1) awv <= 1'b0;
      if (wv && wr_rdy === 1'b1) wv <= 1'b0;
    end while ((awv && awr !== 1'b1) || (wv && wr_rdy !== 1'b1));
    while (bv !== 1'b1) begin
      @(posedge clk);
    end
    rs = bresp;
    br <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    do begin
      @(posedge clk);
    end while (arr !== 1'b1);
    arv <= 1'b0;
    do begin
      @(posedge clk);
    end while (rv !== 1'b1);
    v = rdata;
    rs = rresp;
    rr <= 1'b0;
    @(posedge clk);
  endtask

  // trigger stays quiet while disabled, then follows the condition
  task automatic trig(input logic [7:0] a, input logic [7:0] c, input logic [14:0] p,
                      input int b);
    rx <= aac_rx_s'(p);
    tick(3);
    chk("idle", 32'(tx[b]), 32'h0);
    wr(a, c, r);
    tick(2);
    chk("on", 32'(tx[b]), 32'h1);
    rx <= '0;
    tick(3);
    chk("off", 32'(tx[b]), 32'h0);
    wr(a, 8'h00, r);
  endtask

  task automatic pulse(input logic [14:0] p);
    rx <= aac_rx_s'(p);
    @(posedge clk);
    rx <= '0;
    tick(3);
  endtask

  initial begin
    #400000;
    miscompares++;
    summarize();
  end

  int unsigned tm [2] = '{100, 400};
  logic [7:0]  tc [2] = '{8'h05, 8'h09};
  logic [7:0]  lc [3] = '{8'h10, 8'h40, 8'h80};
  logic [14:0] lon [3] = '{15'h0040, 15'h0010, 15'h0004};
  int          lb [3] = '{7, 7, 6};
  aac_fmt_e    df [6] = '{AAC_FMT_D4_JP, AAC_FMT_D4_US, AAC_FMT_DDS, AAC_FMT_E1,
                          AAC_FMT_E1, AAC_FMT_SLC96};
  logic [7:0]  da [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h10, 8'h18};
  logic [7:0]  dc [6] = '{8'h40, 8'h80, 8'h80, 8'h80, 8'h20, 8'h10};
  int          db [6] = '{5, 4, 2, 3, 9, 1};

  initial begin
    tick(2);
    rst_n <= 1'b1;
    tick(1);
    chk("tx reset", 32'(tx), 32'h0);
    for (int i = 0; i < 8; i++) begin
      rd(8'(4 * i), d, r);
      chk("cfg reset", d, 32'h0);
    end
    wr(8'h00, 8'h5a, r);
    rd(8'h00, d, r);
    chk("readback", d, 32'h5a);
    wr(8'h00, 8'h00, r);
    wr(8'h20, 8'h01, r);
    chk("unmapped wr", 32'(r), 32'(`AAC_RESP_SLVERR));
    wr(`AAC_OFF_STATUS, 8'h01, r);
    chk("ro wr", 32'(r), 32'(`AAC_RESP_SLVERR));
    rd(8'h20, d, r);
    chk("unmapped rd", 32'(r), 32'(`AAC_RESP_SLVERR));
    trig(`AAC_OFF_REMOTE_ALARM, 8'h01, 15'h4000, 12);
    trig(`AAC_OFF_REMOTE_ALARM, 8'h02, 15'h2000, 12);
    trig(`AAC_OFF_REMOTE_ALARM, 8'h04, 15'h1000, 12);
    trig(`AAC_OFF_REMOTE_ALARM, 8'h10, 15'h0400, 12);
    trig(`AAC_OFF_REMOTE_ALARM, 8'h20, 15'h0600, 12);
    trig(`AAC_OFF_EBIT_ACTION, 8'h10, 15'h1000, 11);
    trig(`AAC_OFF_SYS_AIS_LB, 8'h01, 15'h4000, 10);
    trig(`AAC_OFF_TS16_LINE, 8'h10, 15'h2000, 9);
    trig(`AAC_OFF_TS16_SYS, 8'h40, 15'h2000, 8);
    // two triggers on one alarm
    wr(`AAC_OFF_REMOTE_ALARM, 8'h05, r);
    rx <= aac_rx_s'(15'h5000);
    tick(2);
    rx <= aac_rx_s'(15'h1000);
    tick(3);
    chk("rfa one left", 32'(tx.remote_frame_alarm), 32'h1);
    rx <= '0;
    tick(3);
    chk("rfa all clear", 32'(tx.remote_frame_alarm), 32'h0);
    // multiframe-loss timer, both selections
    wr(`AAC_OFF_REMOTE_ALARM, 8'h08, r);
    wr(`AAC_OFF_EBIT_ACTION, 8'h20, r);
    wr(`AAC_OFF_SYS_AIS_LB, 8'h02, r);
    for (int i = 0; i < 2; i++) begin
      wr(`AAC_OFF_MF_TIMER, tc[i], r);
      rx <= aac_rx_s'(15'h1000);
      tick(tm[i] * MS - 20);
      chk("tmr early", 32'(tx[12:10]), 32'h0);
      tick(40);
      chk("tmr expired", 32'(tx[12:10]), 32'h7);
      rd(`AAC_OFF_STATUS, d, r);
      chk("status", d, 32'h87);
      rx <= '0;
      tick(3);
      chk("tmr cleared", 32'(tx[12:10]), 32'h0);
    end
    wr(`AAC_OFF_REMOTE_ALARM, 8'h00, r);
    wr(`AAC_OFF_EBIT_ACTION, 8'h08, r);
    rx <= aac_rx_s'(15'h0800);
    @(posedge clk);
    rx <= '0;
    @(posedge clk);
    chk("ebit crc", 32'(tx.ebit_zero), 32'h1);
    @(posedge clk);
    chk("ebit crc end", 32'(tx.ebit_zero), 32'h0);
    wr(`AAC_OFF_EBIT_ACTION, 8'h00, r);
    // loopbacks: disabled code ignored, then on and off
    wr(`AAC_OFF_SYS_AIS_LB, 8'h00, r);
    pulse(15'h0040);
    chk("lb disabled", 32'(tx.line_loopback), 32'h0);
    for (int i = 0; i < 3; i++) begin
      wr(`AAC_OFF_SYS_AIS_LB, lc[i], r);
      pulse(lon[i]);
      chk("lb on", 32'(tx[lb[i]]), 32'h1);
      pulse(lon[i] >> 1);
      chk("lb off", 32'(tx[lb[i]]), 32'h0);
    end
    wr(`AAC_OFF_SYS_AIS_LB, 8'h00, r);
    // on-demand per format
    for (int i = 0; i < 6; i++) begin
      fmt <= df[i];
      wr(da[i], dc[i], r);
      tick(2);
      chk("demand", 32'(tx[db[i]]), 32'h1);
      if (i == 5) begin
        tick(40);
        chk("squelch", hist[7:0], 32'hff);
      end
      wr(da[i], 8'h00, r);
      tick(2);
      chk("demand off", 32'(tx[db[i]]), 32'h0);
    end
    fmt <= AAC_FMT_ESF;
    wr(`AAC_OFF_REMOTE_ALARM, 8'h80, r);
    tick(200);
    ok = 1'b0;
    for (int k = 0; k < 16; k++) if (hist[15:0] === 16'(32'hff00ff00 >> k)) ok = 1'b1;
    chk("esf pattern", 32'(ok), 32'h1);
    chk("esf repeat", 32'(hist[31:16]), 32'(hist[15:0]));
    summarize();
  end
endmodule // aac_alarm_ctrl_tb
`default_nettype wire
